// >>> hw/gdr_controller.sv
/*
 Controller end: Avalon-MM slave with waitrequest that lets software
 poll one holding register and issue the remove-lock command.
 Assumes the detector answers every request with one ack pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module gdr_controller
    import gdr_pkg::*;
(
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Link to the detector
    gdr_link_if.ctl LINK
);
    import gdr_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } gdr_state_t;

    gdr_state_t state_ff;
    logic bus_ack_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic exc_ff;
    logic unlock_ff;
    logic wr_cmd;
    logic busy;

    assign busy = state_ff == ST_WAIT;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !bus_ack_ff;
    assign wr_cmd = CE && AVS_WRITE && bus_ack_ff && AVS_ADDRESS == CTL_CMD;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bus_ack_ff <= 1'b0;
        end else if (CE) begin
            bus_ack_ff <= (AVS_READ || AVS_WRITE) && !bus_ack_ff;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            AVS_READDATA <= UNMAPPED_WORD;
        end else if (CE && AVS_READ && !bus_ack_ff) begin
            case (AVS_ADDRESS)
                CTL_ADDR: AVS_READDATA <= {16'h0000, addr_ff};
                CTL_RDATA: AVS_READDATA <= {16'h0000, rdata_ff};
                CTL_STAT: AVS_READDATA <= {30'h0, exc_ff, busy};
                default: AVS_READDATA <= UNMAPPED_WORD;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            addr_ff <= REG_STATUS;
        end else if (CE && AVS_WRITE && bus_ack_ff &&
                     AVS_ADDRESS == CTL_ADDR) begin
            addr_ff <= AVS_WRITEDATA[ADDR_W-1:0];
        end
    end

    // A poll command while busy is dropped
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            rdata_ff <= 16'h0000;
            exc_ff <= 1'b0;
        end else if (CE) begin
            case (state_ff)
                ST_IDLE: begin
                    if (wr_cmd && AVS_WRITEDATA[CMD_POLL]) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (LINK.ack) begin
                        rdata_ff <= LINK.rdata;
                        exc_ff <= LINK.exc;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Software alone judges whether the gas is back in range
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            unlock_ff <= 1'b0;
        end else if (CE) begin
            unlock_ff <= wr_cmd && AVS_WRITEDATA[CMD_UNLOCK];
        end
    end

    assign LINK.req = busy;
    assign LINK.fcode = FC_READ_HOLDING;
    assign LINK.addr = addr_ff;
    assign LINK.unlock = unlock_ff && CE;

endmodule // gdr_controller

`default_nettype wire

// >>> hw/gdr_detector.sv
/*
 Detector end: holding register bank with status flags, reported
 concentration, sample counter and the sensor overload lock.
 Assumes measurement inputs come from logic on CORE_CLK, and that the
 controller holds a request on the link until it sees ack.
*/
// Chosen here: register access over the controller link, with a function code.
`timescale 1ns/10ps
`default_nettype none

module gdr_detector
    import gdr_pkg::*;
(
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // Link to the controller
    gdr_link_if.dev LINK,
    // Measurement from the sensor front end
    input wire logic MEAS_VALID,
    input wire logic [gdr_pkg::DATA_W-1:0] MEAS_CONC,
    input wire logic COARSE_RANGE,
    // Threshold levels, same scale as the concentration
    input wire logic [gdr_pkg::DATA_W-1:0] WARN1_LEVEL,
    input wire logic [gdr_pkg::DATA_W-1:0] WARN2_LEVEL,
    input wire logic [gdr_pkg::DATA_W-1:0] ALARM_LEVEL,
    // Detector conditions
    input wire logic CRIT_FAIL,
    input wire logic NONCRIT_FAIL,
    input wire logic CALIB_MODE,
    input wire logic TEST_MODE,
    input wire logic WARM_UP,
    input wire logic INHIBIT,
    // Sensor and display
    output logic SENSOR_ON,
    output logic DISPLAY_LOCK,
    output logic [gdr_pkg::DATA_W-1:0] READING
);
    import gdr_pkg::*;

    logic lock_ff;
    logic nxt_lock;
    logic [DATA_W-1:0] conc_ff;
    logic [DATA_W-1:0] samples_ff;
    logic [DATA_W-1:0] nxt_samples;
    logic thr_ff [3];
    logic overload_ff;
    logic ack_ff;
    logic exc_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] levels [3];
    logic meas_take;
    logic over_range;
    logic lock_shown;

    assign levels[0] = WARN1_LEVEL;
    assign levels[1] = WARN2_LEVEL;
    assign levels[2] = ALARM_LEVEL;

    // While locked the sensor is off, so no fresh sample is accepted
    assign meas_take = MEAS_VALID && !lock_ff;
    assign over_range = MEAS_CONC > CONC_FULL_SCALE;

    // Inhibit hides the lock without stopping it
    assign lock_shown = lock_ff && !INHIBIT;

    // Lock: entry beats a same-cycle remove-lock, reset always clears
    always_comb begin
        nxt_lock = lock_ff;
        if (LINK.unlock) begin
            nxt_lock = 1'b0;
        end
        if (meas_take && over_range) begin
            nxt_lock = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lock_ff <= 1'b0;
        end else if (CE) begin
            lock_ff <= nxt_lock;
        end
    end

    // The over-range sample is not stored: the last good one is kept
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            conc_ff <= RESET_WORD;
        end else if (CE && meas_take && !over_range) begin
            conc_ff <= MEAS_CONC;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            overload_ff <= 1'b0;
        end else if (CE && meas_take) begin
            overload_ff <= over_range;
        end
    end

    // Sample counter with wrap past its top value
    always_comb begin
        if (samples_ff == SAMPLE_MAX) begin
            nxt_samples = RESET_WORD;
        end else begin
            nxt_samples = samples_ff + 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            samples_ff <= RESET_WORD;
        end else if (CE && meas_take) begin
            samples_ff <= nxt_samples;
        end
    end

    // Threshold flags follow each accepted sample
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_thr
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    thr_ff[gi] <= 1'b0;
                end else if (CE && meas_take) begin
                    thr_ff[gi] <= MEAS_CONC >= levels[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        status_word = RESET_WORD;
        status_word[BIT_WARN1] = thr_ff[0];
        status_word[BIT_WARN2] = thr_ff[1];
        status_word[BIT_ALARM] = thr_ff[2];
        status_word[BIT_CRIT] = CRIT_FAIL;
        status_word[BIT_NONCRIT] = NONCRIT_FAIL;
        status_word[BIT_COARSE] = COARSE_RANGE;
        status_word[BIT_OVERLOAD] = overload_ff;
        status_word[BIT_LOCK] = lock_shown;
        status_word[BIT_CALIB] = CALIB_MODE;
        status_word[BIT_TEST] = TEST_MODE;
        status_word[BIT_WARMUP] = WARM_UP;
    end

    // One ack per held request; the gap cycle stops a double answer
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ack_ff <= 1'b0;
        end else if (CE) begin
            ack_ff <= LINK.req && !ack_ff;
        end
    end

    // Register decode; anything but a holding read is refused
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_ff <= RESET_WORD;
            exc_ff <= 1'b0;
        end else if (CE && LINK.req && !ack_ff) begin
            exc_ff <= 1'b0;
            rdata_ff <= RESET_WORD;
            if (LINK.fcode != FC_READ_HOLDING) begin
                exc_ff <= 1'b1;
            end else begin
                case (LINK.addr)
                    REG_STATUS: begin
                        rdata_ff <= status_word;
                    end
                    REG_CONC: begin
                        rdata_ff <= conc_ff;
                    end
                    REG_SAMPLES: begin
                        rdata_ff <= samples_ff;
                    end
                    REG_UNUSED_A, REG_UNUSED_B: begin
                        rdata_ff <= RESET_WORD;
                    end
                    default: begin
                        exc_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign LINK.ack = ack_ff;
    assign LINK.exc = exc_ff;
    assign LINK.rdata = rdata_ff;

    // Sensor power and display driven from flops
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SENSOR_ON <= 1'b1;
            DISPLAY_LOCK <= 1'b0;
            READING <= RESET_WORD;
        end else if (CE) begin
            SENSOR_ON <= !nxt_lock;
            DISPLAY_LOCK <= nxt_lock && !INHIBIT;
            READING <= conc_ff;
        end
    end

endmodule // gdr_detector

`default_nettype wire

// >>> include/gdr_link_if.sv
/*
 Link between the polling controller and the detector register bank.
 Assumes both ends share one clock; the bench joins the two modports.
*/
`timescale 1ns/10ps
`default_nettype none

interface gdr_link_if;
    import gdr_pkg::*;
    logic req;
    logic [FCODE_W-1:0] fcode;
    logic [ADDR_W-1:0] addr;
    logic ack;
    logic exc;
    logic [DATA_W-1:0] rdata;
    logic unlock;

    modport dev (input req, input fcode, input addr, input unlock,
                 output ack, output exc, output rdata);
    modport ctl (output req, output fcode, output addr, output unlock,
                 input ack, input exc, input rdata);
endinterface : gdr_link_if

`default_nettype wire

// >>> include/gdr_pkg.sv
/*
 Shared constants for the gas detector status register bank and its
 polling controller: register numbers, status bit positions, scaling
 and the controller's own register map.
 Assumes both ends run on one 20 MHz clock with a synchronous reset.
*/
`default_nettype none

package gdr_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int FCODE_W = 8;

    // Function code for reading holding registers
    localparam logic [7:0] FC_READ_HOLDING = 8'h03;

    // Holding register numbers
    localparam logic [15:0] REG_STATUS = 16'h9c41;
    localparam logic [15:0] REG_UNUSED_A = 16'h9c42;
    localparam logic [15:0] REG_CONC = 16'h9c43;
    localparam logic [15:0] REG_UNUSED_B = 16'h9c44;
    localparam logic [15:0] REG_SAMPLES = 16'h9c45;

    // Status word bit positions
    localparam int BIT_WARN1 = 0;
    localparam int BIT_WARN2 = 1;
    localparam int BIT_ALARM = 2;
    localparam int BIT_CRIT = 3;
    localparam int BIT_NONCRIT = 4;
    localparam int BIT_COARSE = 5;
    localparam int BIT_OVERLOAD = 6;
    localparam int BIT_LOCK = 7;
    localparam int BIT_CALIB = 8;
    localparam int BIT_TEST = 9;
    localparam int BIT_WARMUP = 10;

    // Concentration scaling and sample counter span
    localparam logic [15:0] CONC_FULL_SCALE = 16'h03e8;
    localparam logic [15:0] SAMPLE_MAX = 16'hff49;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Controller register map, byte addresses
    localparam logic [3:0] CTL_CMD = 4'h0;
    localparam logic [3:0] CTL_ADDR = 4'h4;
    localparam logic [3:0] CTL_RDATA = 4'h8;
    localparam logic [3:0] CTL_STAT = 4'hc;
    localparam int CMD_POLL = 0;
    localparam int CMD_UNLOCK = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_EXC = 1;
    localparam logic [31:0] UNMAPPED_WORD = 32'h00000000;
endpackage : gdr_pkg

`default_nettype wire

// >>> test/gdr_props.sv
/*
 Link checker: request, answer and pulse rules between the two ends.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module gdr_props
    import gdr_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Link
    input wire logic req,
    input wire logic [gdr_pkg::FCODE_W-1:0] fcode,
    input wire logic [gdr_pkg::ADDR_W-1:0] addr,
    input wire logic ack,
    input wire logic exc,
    input wire logic [gdr_pkg::DATA_W-1:0] rdata,
    input wire logic unlock
);
    import gdr_pkg::*;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // One ack, then the request is withdrawn
    sequence s_answer;
        ack ##1 (!req && !ack);
    endsequence

    AST_HANDSHAKE: assert property ($rose(req) |=> s_answer)
        else $error("link request not answered in one cycle");
    AST_NO_STRAY_ACK: assert property (ack |-> $past(req))
        else $error("ack without a request");
    AST_FCODE: assert property (req |-> fcode == FC_READ_HOLDING)
        else $error("request with a wrong function code");
    AST_EXC: assert property (
        ack |-> exc == (addr < REG_STATUS || addr > REG_SAMPLES))
        else $error("exception flag does not match the address");
    AST_ZERO_WORD: assert property (
        ack && (exc || addr == REG_UNUSED_A || addr == REG_UNUSED_B)
        |-> rdata == 16'h0000) else $error("refused or spare word not zero");
    AST_SPARE_BITS: assert property (
        ack && addr == REG_STATUS |-> rdata[15:11] == 5'h00)
        else $error("undefined status bits set");
    AST_CONC_SCALE: assert property (
        ack && addr == REG_CONC |-> rdata <= CONC_FULL_SCALE)
        else $error("concentration above full scale");
    AST_CNT_SPAN: assert property (
        ack && addr == REG_SAMPLES |-> rdata <= SAMPLE_MAX)
        else $error("sample counter beyond its span");
    // Reset clears the read data, so the cycle of reset is left out
    AST_RDATA_HOLD: assert property (!req && !RST |=> $stable(rdata))
        else $error("read data changed between requests");
    AST_UNLOCK_PULSE: assert property (unlock |=> !unlock)
        else $error("unlock pulse longer than one cycle");
endmodule : gdr_props

`default_nettype wire

// >>> test/gdr_tb_top.sv
/*
 Bench joining controller and detector; software reads through Avalon.
 Assumes nothing of the slave's latency; a watchdog bounds every wait.
*/
`timescale 1ns/10ps
`default_nettype none

module gdr_tb_top;
    import gdr_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m;} gdr_exp_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic meas_valid = 1'b0;
    logic [15:0] meas_conc = 16'h0000;
    logic [5:0] cond = 6'h00;
    logic inhibit = 1'b0;
    logic [15:0] w1 = 16'h0064;
    logic [15:0] w2 = 16'h00c8;
    logic [15:0] al = 16'h01f4;
    logic sensor_on;
    logic display_lock;
    logic [15:0] reading;
    logic [15:0] last_v = 16'h0000;
    logic [15:0] bnd [6] = '{16'h0064, 16'h00c7, 16'h00c8, 16'h01f3,
                             16'h01f4, 16'h03e8};
    logic [15:0] regs [7] = '{REG_STATUS, REG_UNUSED_A, REG_CONC,
                              REG_UNUSED_B, REG_SAMPLES, 16'h9c40, 16'h9c46};
    logic lk = 1'b0;
    int cnt = 0;
    int failures = 0;
    int total_checks = 0;
    gdr_exp_t exp_q[$];

    gdr_link_if link();
    gdr_detector i_gdr_detector(.CORE_CLK(core_clk), .RST(rst), .CE(ce),
        .LINK(link), .MEAS_VALID(meas_valid), .MEAS_CONC(meas_conc),
        .COARSE_RANGE(cond[5]), .WARN1_LEVEL(w1), .WARN2_LEVEL(w2),
        .ALARM_LEVEL(al), .CRIT_FAIL(cond[4]), .NONCRIT_FAIL(cond[3]),
        .CALIB_MODE(cond[2]), .TEST_MODE(cond[1]), .WARM_UP(cond[0]),
        .INHIBIT(inhibit), .SENSOR_ON(sensor_on),
        .DISPLAY_LOCK(display_lock), .READING(reading));
    gdr_controller i_gdr_controller(.CORE_CLK(core_clk), .RST(rst),
        .CE(ce), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .LINK(link));
    gdr_props i_gdr_props(.CORE_CLK(core_clk), .RST(rst), .req(link.req),
        .fcode(link.fcode), .addr(link.addr), .ack(link.ack),
        .exc(link.exc), .rdata(link.rdata), .unlock(link.unlock));

    always #25 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic av_cycle(input logic [3:0] a, input logic wr,
                            input logic [31:0] wd);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m);
        exp_q.push_back('{d, m});
        av_cycle(a, 1'b0, 32'h0);
    endtask

    // Four cycles cover the link walk from command to idle
    task automatic poll(input logic [15:0] r, input logic [15:0] d,
                        input logic [15:0] m, input logic e);
        av_cycle(CTL_ADDR, 1'b1, {16'h0000, r});
        av_cycle(CTL_CMD, 1'b1, 32'h1 << CMD_POLL);
        repeat (4) @(posedge core_clk);
        rd(CTL_STAT, {30'h0, e, 1'b0}, 32'h3);
        rd(CTL_RDATA, {16'h0000, d}, {16'hffff, m});
    endtask

    task automatic meas(input logic [15:0] v);
        @(posedge core_clk);
        meas_valid <= 1'b1;
        meas_conc <= v;
        @(posedge core_clk);
        meas_valid <= 1'b0;
        // An over-range sample is still counted, but not stored
        if (!lk) begin
            cnt = (cnt == SAMPLE_MAX) ? 0 : cnt + 1;
            if (v > CONC_FULL_SCALE) lk = 1'b1;
            else last_v = v;
        end
    endtask

    function automatic logic [15:0] stat_exp();
        logic [15:0] s;
        s = 16'h0000;
        s[BIT_WARN1] = last_v >= w1;
        s[BIT_WARN2] = last_v >= w2;
        s[BIT_ALARM] = last_v >= al;
        {s[BIT_COARSE], s[BIT_CRIT], s[BIT_NONCRIT]} = cond[5:3];
        {s[BIT_CALIB], s[BIT_TEST], s[BIT_WARMUP]} = cond[2:0];
        return s;
    endfunction

    // Oldest note is matched at the edge where waitrequest is seen low
    always @(posedge core_clk) begin
        gdr_exp_t e;
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(avs_readdata & e.m, e.d & e.m);
        end
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        finish_test();
    end

    initial begin
        void'($urandom(61));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(CTL_ADDR, {16'h0000, REG_STATUS}, 32'hffffffff);
        rd(4'h2, UNMAPPED_WORD, 32'hffffffff);
        for (int i = 0; i < 7; i++)
            poll(regs[i], 16'h0000, 16'hffff, i > 4);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            cond <= 6'($urandom);
            meas((i < 6) ? bnd[i] : 16'($urandom % 1001));
            poll(REG_STATUS, stat_exp(), 16'hffff, 1'b0);
            poll(REG_CONC, last_v, 16'hffff, 1'b0);
            poll(REG_SAMPLES, 16'(cnt), 16'hffff, 1'b0);
            check(reading, last_v);
        end
        $display("test flags and scaling done");
        @(posedge core_clk);
        meas_valid <= 1'b1;
        meas_conc <= 16'h000a;
        repeat (65353 - cnt) @(posedge core_clk);
        meas_valid <= 1'b0;
        cnt = 65353;
        last_v = 16'h000a;
        poll(REG_SAMPLES, SAMPLE_MAX, 16'hffff, 1'b0);
        meas(16'h000a);
        poll(REG_SAMPLES, 16'h0000, 16'hffff, 1'b0);
        $display("test counter wrap done");
        ce <= 1'b0;
        meas_valid <= 1'b1;
        meas_conc <= 16'h03e9;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
        meas_valid <= 1'b0;
        poll(REG_SAMPLES, 16'(cnt), 16'hffff, 1'b0);
        poll(REG_STATUS, 16'h0000, 16'h00c0, 1'b0);
        $display("test clock enable done");
        meas(16'h03e9);
        repeat (2) @(posedge core_clk);
        check(sensor_on, 32'h0);
        check(display_lock, 32'h1);
        poll(REG_STATUS, 16'h00c0, 16'h00c0, 1'b0);
        meas(16'h012c);
        poll(REG_CONC, last_v, 16'hffff, 1'b0);
        check(reading, last_v);
        poll(REG_SAMPLES, 16'(cnt), 16'hffff, 1'b0);
        av_cycle(CTL_CMD, 1'b1, 32'h1 << CMD_UNLOCK);
        repeat (3) @(posedge core_clk);
        lk = 1'b0;
        check(sensor_on, 32'h1);
        check(display_lock, 32'h0);
        poll(REG_STATUS, 16'h0000, 16'h0080, 1'b0);
        $display("test lock and unlock done");
        inhibit <= 1'b1;
        meas(16'h05dc);
        repeat (2) @(posedge core_clk);
        check(sensor_on, 32'h0);
        check(display_lock, 32'h0);
        poll(REG_STATUS, 16'h0000, 16'h0080, 1'b0);
        inhibit <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(display_lock, 32'h1);
        poll(REG_STATUS, 16'h0080, 16'h0080, 1'b0);
        $display("test inhibited lock done");
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(sensor_on, 32'h1);
        check(display_lock, 32'h0);
        poll(REG_SAMPLES, 16'h0000, 16'hffff, 1'b0);
        poll(REG_CONC, 16'h0000, 16'hffff, 1'b0);
        $display("test power removal done");
        finish_test();
    end
endmodule : gdr_tb_top

`default_nettype wire
